// [rtl/rx_pv_pkg.sv]
// constants, codes and helpers shared by the receive pattern verifier block
package rx_pv_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int unsigned NUM_LANES    = 4;
	localparam int unsigned CNT_W        = 12;
	localparam int unsigned CP_W         = 20;
	localparam int unsigned SHORT_CP_LEN = 16;
	localparam int unsigned HIST_W       = 31;
	localparam int unsigned CLK_HALF     = 10;
	localparam int unsigned TOTAL_CNT_W  = NUM_LANES * CNT_W;

	// ------------------------------------------------------------
	// register offsets and reset value
	// ------------------------------------------------------------
	localparam logic [7:0] MODE_CTL_OFS  = 8'h10;
	localparam logic [7:0] CP_LO_OFS     = 8'h11;
	localparam logic [7:0] CP_MID_OFS    = 8'h12;
	localparam logic [7:0] CP_HI_OFS     = 8'h13;
	localparam logic [7:0] THR_OFS       = 8'h14;
	localparam logic [7:0] CLRSEL_OFS    = 8'h15;
	localparam logic [7:0] DPCTL_OFS     = 8'h16;
	localparam logic [7:0] FLAGS_OFS     = 8'h17;
	localparam logic [7:0] REG_RST       = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CUSTOM_LEN_POS = 7;
	localparam int unsigned PRBS_LEN_POS   = 3;
	localparam int unsigned MODE_POS       = 0;
	localparam int unsigned THR_POS        = 0;
	localparam int unsigned ALIGN_POS      = 7;
	localparam int unsigned CNT_CLR_POS    = 4;
	localparam int unsigned FLAG_CLR_POS   = 3;
	localparam int unsigned FLAG_SRC_POS   = 0;
	localparam int unsigned DP_EN_POS      = 4;
	localparam int unsigned DP_SEL_POS     = 0;
	localparam int unsigned LATCHED_POS    = 4;
	localparam int unsigned LIVE_POS       = 0;

	// ------------------------------------------------------------
	// codes and counts
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_PRBS     = 3'h1;
	localparam logic [2:0] MODE_CLOCK    = 3'h2;
	localparam logic [2:0] MODE_CUSTOM   = 3'h3;
	localparam logic [2:0] DP_DISPARITY  = 3'h0;
	localparam logic [2:0] DP_FIFO_ERR   = 3'h1;
	localparam logic [2:0] DP_OVF        = 3'h2;
	localparam logic [2:0] DP_UDF        = 3'h3;
	localparam logic [2:0] DP_DESKEW     = 3'h4;
	localparam logic [2:0] FSRC_MISMATCH = 3'h0;
	localparam logic [2:0] FSRC_SYNC     = 3'h1;
	localparam logic [2:0] FSRC_NONZERO  = 3'h2;
	localparam logic [2:0] FSRC_SAT      = 3'h3;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
	localparam logic [3:0] SYNC_CYCLES   = 4'h8;

	// sequence degree chosen by the length code
	function automatic logic [4:0] prbs_degree(input logic [2:0] code);
		case (code)
			3'h0:         prbs_degree = 5'h07;
			3'h1:         prbs_degree = 5'h0b;
			3'h2:         prbs_degree = 5'h17;
			3'h3:         prbs_degree = 5'h1f;
			3'h4, 3'h5:   prbs_degree = 5'h0f;
			default:      prbs_degree = 5'h14;
		endcase
	endfunction

	// inner feedback tap of the same polynomial
	function automatic logic [4:0] prbs_tap(input logic [2:0] code);
		case (code)
			3'h0:         prbs_tap = 5'h06;
			3'h1:         prbs_tap = 5'h09;
			3'h2:         prbs_tap = 5'h12;
			3'h3:         prbs_tap = 5'h1c;
			3'h4, 3'h5:   prbs_tap = 5'h0e;
			default:      prbs_tap = 5'h03;
		endcase
	endfunction
endpackage

// [rtl/lane_cfg_if.sv]
// per-lane settings and results between the control block and a lane checker
`timescale 1ns/100ps
interface lane_cfg_if import rx_pv_pkg::*; ();
	logic [2:0]       mode;
	logic [2:0]       prbs_len;
	logic             custom_len;
	logic [CP_W-1:0]  pattern;
	logic             rx_bit;
	logic             dp_active;
	logic             dp_event;
	logic             count_clear;
	logic [CNT_W-1:0] err_count;
	logic             mismatch;

	modport ctl (output mode, prbs_len, custom_len, pattern, rx_bit, dp_active, dp_event,
		count_clear, input err_count, mismatch);
	modport lane (input mode, prbs_len, custom_len, pattern, rx_bit, dp_active, dp_event,
		count_clear, output err_count, mismatch);
endinterface

// [rtl/sync_timer.sv]
// per-lane sequence period timer producing the pattern timing pulse
`timescale 1ns/100ps
module sync_timer import rx_pv_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       active,
	input  wire logic [2:0] prbs_len,
	output logic            sync_pulse
);
	logic [HIST_W-1:0] pos_q;
	logic [HIST_W-1:0] last;
	logic [3:0]        width_q;
	logic              wrap;

	// one position per received bit, so a full sequence is 2^n-1 cycles
	assign last = HIST_W'((32'h1 << prbs_degree(prbs_len)) - 32'h2);
	assign wrap = active && (pos_q == last);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q <= '0;
		end else if (!active || wrap) begin
			pos_q <= '0;
		end else begin
			pos_q <= pos_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			width_q    <= 4'h0;
			sync_pulse <= 1'b0;
		end else if (wrap) begin
			width_q    <= SYNC_CYCLES - 4'h1;
			sync_pulse <= 1'b1;
		end else if (width_q != 4'h0) begin
			width_q    <= width_q - 4'h1;
		end else begin
			sync_pulse <= 1'b0;
		end
	end
endmodule

// [rtl/lane_checker.sv]
// per-lane received bit comparison and saturating error counter
`timescale 1ns/100ps
module lane_checker import rx_pv_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	lane_cfg_if.lane lc
);
	logic [HIST_W-1:0] hist_q;
	logic [CNT_W-1:0]  count_q;
	logic              locked_q;
	logic              mismatch_q;
	logic              mismatch_d;
	logic              hit;
	logic              ev;
	logic [4:0]        deg;
	logic [4:0]        tap;
	logic [4:0]        cp_len;

	// hist_q[0] is the bit received one cycle ago
	always_comb begin
		deg    = prbs_degree(lc.prbs_len);
		tap    = prbs_tap(lc.prbs_len);
		cp_len = lc.custom_len ? 5'(CP_W) : 5'(SHORT_CP_LEN);
		hit    = lc.custom_len ? (hist_q[CP_W-1:0] == lc.pattern) :
			(hist_q[SHORT_CP_LEN-1:0] == lc.pattern[SHORT_CP_LEN-1:0]);
		mismatch_d = 1'b0;
		if (!lc.mode[2]) begin
			case (lc.mode)
				MODE_PRBS:   mismatch_d = lc.rx_bit ^ hist_q[deg-5'h1] ^ hist_q[tap-5'h1];
				MODE_CLOCK:  mismatch_d = lc.rx_bit == hist_q[CLK_HALF-1];
				MODE_CUSTOM: mismatch_d = locked_q && (lc.rx_bit != hist_q[cp_len-5'h1]);
				default:     mismatch_d = 1'b0;
			endcase
		end
		ev = lc.dp_active ? lc.dp_event : mismatch_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_q <= '0;
		end else begin
			hist_q <= {hist_q[HIST_W-2:0], lc.rx_bit};
		end
	end

	// custom checking waits until the stored word has been seen once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			locked_q <= 1'b0;
		end else begin
			locked_q <= (lc.mode == MODE_CUSTOM) && (locked_q || hit);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mismatch_q <= 1'b0;
		end else begin
			mismatch_q <= mismatch_d && !lc.dp_active;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (lc.count_clear) begin
			count_q <= '0;
		end else if (ev && count_q != CNT_MAX) begin
			count_q <= count_q + 1'b1;
		end
	end

	assign lc.err_count = count_q;
	assign lc.mismatch  = mismatch_q;
endmodule

// [rtl/rx_pattern_verifier_ctl.sv]
// control and status registers of the four-lane receive pattern verifier
//
// Functional notes
// - custom length bit selects 16-bit (clear) or 20-bit (set) compare; resets clear.
// - length code picks PRBS7/11/23/31, 100-101 PRBS15, 110-111 PRBS20.
// - mode code: off, PRBS, clock, custom; top bit set means timing only.
// - timing only never compares; sync pulses spaced by the chosen sequence period.
// - custom word in three registers; top nibble compared only in 20-bit length.
// - read-only alignment-done bit follows lane deskew completion; resets low.
// - software sets counter-clear; counters clear on its rising edge; bit self-clears.
// - software sets flag-clear; latched lane flags clear; bit self-clears.
// - three-bit writable field picks the live flag source; resets to zero.
// - per-lane enable moves that lane's checking onto selected live datapath events.
// - event select: disparity, fifo error, overflow, underflow, deskew; rest reserved.
// - with any enable set, lane 0 count and flags report the selected event.
// - latched flags of four lanes read in flag register bits 7:4.
// - live flags of four lanes read in flag register bits 3:0.
// - settings pass to a lane while its load bit is high; held after fall.
// - each lane's timing pulse lasts eight bits once per sequence cycle.
// - each lane not moved onto datapath events reports a mismatch bit when received data disagrees.
// - each lane keeps a twelve-bit read-only error count.
`timescale 1ns/100ps
module rx_pattern_verifier_ctl import rx_pv_pkg::*; (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	input  wire logic [NUM_LANES-1:0]   lane_settings_load,
	input  wire logic [NUM_LANES-1:0]   rx_bit,
	input  wire logic                   lane_align_done,
	input  wire logic [NUM_LANES-1:0]   disparity_err,
	input  wire logic [NUM_LANES-1:0]   fifo_err,
	input  wire logic [NUM_LANES-1:0]   fifo_overflow,
	input  wire logic [NUM_LANES-1:0]   fifo_underflow,
	output logic      [NUM_LANES-1:0]   pattern_sync_pulse,
	output logic      [NUM_LANES-1:0]   mismatch_det,
	output logic      [TOTAL_CNT_W-1:0] lane_error_count,
	output logic      [2:0]             retain_threshold_value
);
	// ------------------------------------------------------------
	// software settings
	// ------------------------------------------------------------
	logic                 custom_len_sel_q;
	logic [2:0]           prbs_length_code_q;
	logic [2:0]           verify_mode_sel_q;
	logic [7:0]           cp_lo_q;
	logic [7:0]           cp_mid_q;
	logic [3:0]           cp_hi_q;
	logic [2:0]           thr_q;
	logic [2:0]           flag_source_sel_q;
	logic [NUM_LANES-1:0] live_path_check_en_q;
	logic [2:0]           live_path_event_sel_q;
	logic                 error_count_clear_q;
	logic                 clr_prev_q;
	logic                 latched_flag_clear_q;
	logic                 lane_align_done_q;
	logic [7:0]           rdata_d;
	logic                 wr_clrsel;
	logic                 clr_pulse;

	// ------------------------------------------------------------
	// per-lane held settings and status
	// ------------------------------------------------------------
	logic [2:0]           lane_mode_q    [NUM_LANES];
	logic [2:0]           lane_len_q     [NUM_LANES];
	logic [CP_W-1:0]      lane_pat_q     [NUM_LANES];
	logic [NUM_LANES-1:0] lane_cplen_q;
	logic [NUM_LANES-1:0] live_lane_flag_q;
	logic [NUM_LANES-1:0] latched_lane_flag_q;
	logic [NUM_LANES-1:0] live_d;
	logic [NUM_LANES-1:0] dp_ev;
	logic [NUM_LANES-1:0] mism_v;
	logic [CNT_W-1:0]     cnt_v          [NUM_LANES];
	logic [CP_W-1:0]      custom_pattern_word;
	logic                 dp_any;

	assign custom_pattern_word    = {cp_hi_q, cp_mid_q, cp_lo_q};
	assign retain_threshold_value = thr_q;
	assign dp_any                 = |live_path_check_en_q;
	assign wr_clrsel              = reg_wr && (reg_addr == CLRSEL_OFS);
	assign clr_pulse              = error_count_clear_q && !clr_prev_q;

	// event of one lane picked by the datapath select code
	function automatic logic ev_pick(input logic [2:0] sel, input logic disp,
		input logic ferr, input logic ovf, input logic udf, input logic aligned);
		case (sel)
			DP_DISPARITY: ev_pick = disp;
			DP_FIFO_ERR:  ev_pick = ferr;
			DP_OVF:       ev_pick = ovf;
			DP_UDF:       ev_pick = udf;
			DP_DESKEW:    ev_pick = !aligned;
			default:      ev_pick = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			custom_len_sel_q      <= 1'b0;
			prbs_length_code_q    <= 3'h0;
			verify_mode_sel_q     <= 3'h0;
			cp_lo_q               <= REG_RST;
			cp_mid_q              <= REG_RST;
			cp_hi_q               <= 4'h0;
			thr_q                 <= 3'h0;
			flag_source_sel_q     <= 3'h0;
			live_path_check_en_q  <= 4'h0;
			live_path_event_sel_q <= 3'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				MODE_CTL_OFS: begin
					custom_len_sel_q   <= reg_wdata[CUSTOM_LEN_POS];
					prbs_length_code_q <= reg_wdata[PRBS_LEN_POS +: 3];
					verify_mode_sel_q  <= reg_wdata[MODE_POS +: 3];
				end
				CP_LO_OFS:  cp_lo_q  <= reg_wdata;
				CP_MID_OFS: cp_mid_q <= reg_wdata;
				CP_HI_OFS:  cp_hi_q  <= reg_wdata[3:0];
				THR_OFS:    thr_q    <= reg_wdata[THR_POS +: 3];
				CLRSEL_OFS: flag_source_sel_q <= reg_wdata[FLAG_SRC_POS +: 3];
				DPCTL_OFS: begin
					live_path_check_en_q  <= reg_wdata[DP_EN_POS +: NUM_LANES];
					live_path_event_sel_q <= reg_wdata[DP_SEL_POS +: 3];
				end
				default: ;
			endcase
		end
	end

	// clear requests read back as set for one cycle, then drop by themselves
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			error_count_clear_q  <= 1'b0;
			clr_prev_q           <= 1'b0;
			latched_flag_clear_q <= 1'b0;
		end else begin
			error_count_clear_q  <= wr_clrsel && reg_wdata[CNT_CLR_POS];
			clr_prev_q           <= error_count_clear_q;
			latched_flag_clear_q <= wr_clrsel && reg_wdata[FLAG_CLR_POS];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_align_done_q <= 1'b0;
		end else begin
			lane_align_done_q <= lane_align_done;
		end
	end

	// ------------------------------------------------------------
	// per-lane settings hand-off
	// ------------------------------------------------------------
	// a lane follows the shared settings only while its load bit is high,
	// so lanes can run different patterns from one register set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_cplen_q <= '0;
			for (int i = 0; i < NUM_LANES; i++) begin
				lane_mode_q[i] <= 3'h0;
				lane_len_q[i]  <= 3'h0;
				lane_pat_q[i]  <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_LANES; i++) begin
				if (lane_settings_load[i]) begin
					lane_mode_q[i]  <= verify_mode_sel_q;
					lane_len_q[i]   <= prbs_length_code_q;
					lane_pat_q[i]   <= custom_pattern_word;
					lane_cplen_q[i] <= custom_len_sel_q;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// lanes
	// ------------------------------------------------------------
	lane_cfg_if lif [NUM_LANES] ();

	for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
		assign dp_ev[g] = ev_pick(live_path_event_sel_q, disparity_err[g], fifo_err[g],
			fifo_overflow[g], fifo_underflow[g], lane_align_done_q);
		assign lif[g].mode        = lane_mode_q[g];
		assign lif[g].prbs_len    = lane_len_q[g];
		assign lif[g].custom_len  = lane_cplen_q[g];
		assign lif[g].pattern     = lane_pat_q[g];
		assign lif[g].rx_bit      = rx_bit[g];
		assign lif[g].count_clear = clr_pulse;
		if (g == 0) begin : g_rep
			// lane 0 reports the enabled lanes' selected events
			assign lif[g].dp_active = dp_any;
			assign lif[g].dp_event  = |(dp_ev & live_path_check_en_q);
		end else begin : g_own
			assign lif[g].dp_active = live_path_check_en_q[g];
			assign lif[g].dp_event  = dp_ev[g];
		end
		assign mism_v[g] = lif[g].mismatch;
		assign cnt_v[g]  = lif[g].err_count;
		assign mismatch_det[g] = lif[g].mismatch;
		assign lane_error_count[g*CNT_W +: CNT_W] = lif[g].err_count;

		lane_checker u_chk (
			.clk   (clk),
			.rst_n (rst_n),
			.lc    (lif[g])
		);

		sync_timer u_sync (
			.clk        (clk),
			.rst_n      (rst_n),
			.active     (lane_mode_q[g][2] || lane_mode_q[g] == MODE_PRBS),
			.prbs_len   (lane_len_q[g]),
			.sync_pulse (pattern_sync_pulse[g])
		);
	end

	// ------------------------------------------------------------
	// test flags
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_LANES; i++) begin
			case (flag_source_sel_q)
				FSRC_MISMATCH: live_d[i] = mism_v[i];
				FSRC_SYNC:     live_d[i] = pattern_sync_pulse[i];
				FSRC_NONZERO:  live_d[i] = cnt_v[i] != '0;
				FSRC_SAT:      live_d[i] = cnt_v[i] == CNT_MAX;
				default:       live_d[i] = 1'b0;
			endcase
		end
		if (dp_any) begin
			live_d[0] = |(dp_ev & live_path_check_en_q);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			live_lane_flag_q <= 4'h0;
		end else begin
			live_lane_flag_q <= live_d;
		end
	end

	// a new event in the clearing cycle still sets the flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latched_lane_flag_q <= 4'h0;
		end else begin
			latched_lane_flag_q <= (latched_lane_flag_q & ~{NUM_LANES{latched_flag_clear_q}})
				| live_d;
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = REG_RST;
		case (reg_addr)
			MODE_CTL_OFS: begin
				rdata_d[CUSTOM_LEN_POS]      = custom_len_sel_q;
				rdata_d[PRBS_LEN_POS +: 3]   = prbs_length_code_q;
				rdata_d[MODE_POS +: 3]       = verify_mode_sel_q;
			end
			CP_LO_OFS:  rdata_d = cp_lo_q;
			CP_MID_OFS: rdata_d[7:0] = cp_mid_q;
			CP_HI_OFS:  rdata_d[3:0] = cp_hi_q;
			THR_OFS:    rdata_d[THR_POS +: 3] = thr_q;
			CLRSEL_OFS: begin
				rdata_d[ALIGN_POS]           = lane_align_done_q;
				rdata_d[CNT_CLR_POS]         = error_count_clear_q;
				rdata_d[FLAG_CLR_POS]        = latched_flag_clear_q;
				rdata_d[FLAG_SRC_POS +: 3]   = flag_source_sel_q;
			end
			DPCTL_OFS: begin
				rdata_d[DP_EN_POS +: NUM_LANES] = live_path_check_en_q;
				rdata_d[DP_SEL_POS +: 3]        = live_path_event_sel_q;
			end
			FLAGS_OFS: begin
				rdata_d[LATCHED_POS +: NUM_LANES] = latched_lane_flag_q;
				rdata_d[LIVE_POS +: NUM_LANES]    = live_lane_flag_q;
			end
			default: rdata_d = REG_RST;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= REG_RST;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence flag_clr_req_s;
		wr_clrsel && reg_wdata[FLAG_CLR_POS];
	endsequence
	sequence flag_clr_done_s;
		latched_flag_clear_q ##1 (latched_lane_flag_q == live_lane_flag_q);
	endsequence

	flag_clear_a: assert property (
		flag_clr_req_s |=> flag_clr_done_s) else $error("latched flags not cleared");
	cnt_clear_a: assert property (
		clr_pulse |=> cnt_v[0] == '0) else $error("error count not cleared");
	count_sat_a: assert property (
		cnt_v[1] == CNT_MAX && !clr_pulse |=> cnt_v[1] == CNT_MAX)
		else $error("error count wrapped");
	latch_set_a: assert property (
		(live_lane_flag_q & ~latched_lane_flag_q) == 4'h0) else $error("latch missed live flag");
	latch_hold_a: assert property (
		latched_lane_flag_q[2] && !latched_flag_clear_q |=> latched_lane_flag_q[2])
		else $error("latched flag dropped");
	flag_read_a: assert property (
		reg_rd && reg_addr == FLAGS_OFS |=>
		reg_rdata == {$past(latched_lane_flag_q), $past(live_lane_flag_q)})
		else $error("flag register read wrong");
	align_read_a: assert property (
		reg_rd && reg_addr == CLRSEL_OFS |=> reg_rdata[ALIGN_POS] == $past(lane_align_done_q))
		else $error("alignment bit read wrong");
	dp_report_a: assert property (
		live_path_check_en_q[0] && live_path_event_sel_q == DP_OVF && fifo_overflow[0]
		|=> live_lane_flag_q[0] && latched_lane_flag_q[0]) else $error("lane 0 event lost");
	sync_width_a: assert property (
		$rose(pattern_sync_pulse[0]) |-> pattern_sync_pulse[0][*8] ##1 !pattern_sync_pulse[0])
		else $error("timing pulse width wrong");
	timing_cmp_a: assert property (
		lane_mode_q[0][2] |=> !mismatch_det[0]) else $error("timing mode compared data");
	load_take_a: assert property (
		lane_settings_load[0] |=> lane_mode_q[0] == $past(verify_mode_sel_q))
		else $error("lane did not take settings");
	load_hold_a: assert property (
		!lane_settings_load[0] |=> $stable(lane_mode_q[0])) else $error("lane settings moved");
endmodule

// [sim/rx_pattern_source.sv]
// behavioural video source repeating a 16-bit custom word on the lanes
`timescale 1ns/100ps
module rx_pattern_source (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] word,
	input  wire logic        flip,
	output logic             rx_bit
);
	logic [3:0] idx_q;

	// index runs downward so the newest bit lands at bit 0 of the window and the word can lock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q  <= 4'h0;
			rx_bit <= 1'b0;
		end else begin
			idx_q  <= idx_q - 4'h1;
			rx_bit <= word[idx_q] ^ flip;
		end
	end
endmodule

// [sim/rx_pattern_verifier_ctl_tb_top.sv]
// self-checking bench for the receive pattern verifier control block
`timescale 1ns/100ps
module rx_pattern_verifier_ctl_tb_top import rx_pv_pkg::*; ;
	logic                   clk = 1'b0, rst_n = 1'b0, wr_q = 1'b0, rd_q = 1'b0;
	logic                   align = 1'b0, flip = 1'b0, mm_seen = 1'b0, src;
	logic [7:0]             addr = 8'h00, wdata = 8'h00, rdata;
	logic [3:0]             sync, mm;
	logic [3:0]             ev [6] = '{default: 4'h0};
	logic [2:0]             thr;
	logic [TOTAL_CNT_W-1:0] cnt;
	int                     n_mismatch = 0, n_tests = 0, cyc = 0, hi = 0;

	always #2 clk = ~clk;

	rx_pattern_verifier_ctl i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr_q), .reg_rd(rd_q), .reg_rdata(rdata),
		.lane_settings_load(ev[5]), .rx_bit({4{src}}), .lane_align_done(align & ~ev[4][0]),
		.disparity_err(ev[0]), .fifo_err(ev[1]), .fifo_overflow(ev[2]),
		.fifo_underflow(ev[3]), .pattern_sync_pulse(sync), .mismatch_det(mm),
		.lane_error_count(cnt), .retain_threshold_value(thr));
	rx_pattern_source i_src (.clk(clk), .rst_n(rst_n), .word(16'ha5c3), .flip(flip),
		.rx_bit(src));

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_q = 1'b1;
		@(negedge clk);
		wr_q = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd_q = 1'b1;
		@(negedge clk);
		rd_q = 1'b0;
		check($sformatf("reg %h", a), {4'h0, rdata}, {4'h0, exp});
		@(negedge clk);
	endtask
	// one-cycle strobe; index 5 is the per-lane load bits
	task automatic pulse(input int c, input logic [3:0] m);
		ev[c] = m;
		@(negedge clk);
		ev[c] = 4'h0;
		@(negedge clk);
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog: the whole sequence needs about five thousand cycles, mostly the saturation run
	always @(posedge clk) begin
		cyc++;
		if (mm[2] === 1'b1)
			mm_seen = 1'b1;
		if (cyc == 8000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		for (int a = 16; a < 24; a++)
			rd(8'(a), 8'h00);
		wr(8'h10, 8'hff);
		rd(8'h10, 8'hbf);
		wr(8'h13, 8'hff);
		rd(8'h13, 8'h0f);
		wr(8'h14, 8'hff);
		check("threshold", 12'(thr), 12'h007);
		wr(8'h16, 8'hff);
		rd(8'h16, 8'hf7);
		wr(8'h17, 8'hff);
		rd(8'h17, 8'h00);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		align = 1'b1;
		wr(8'h15, 8'h02);
		rd(8'h15, 8'h82);
		for (int c = 0; c < 5; c++) begin
			wr(8'h16, 8'h10 | 8'(c));
			pulse(c, 4'h1);
		end
		wr(8'h16, 8'h15);
		pulse(0, 4'h1);
		check("lane0 count", cnt[11:0], 12'h005);
		rd(8'h17, 8'h10);
		wr(8'h15, 8'h12);
		repeat (2) @(negedge clk);
		check("lane0 cleared", cnt[11:0], 12'h000);
		rd(8'h17, 8'h10);
		wr(8'h15, 8'h0a);
		rd(8'h17, 8'h00);
		rd(8'h15, 8'h82);
		wr(8'h16, 8'h00);
		wr(8'h10, 8'h04);
		pulse(5, 4'h2);
		while (sync[1] === 1'b1) @(negedge clk);
		while (sync[1] !== 1'b1) @(negedge clk);
		repeat (127) begin
			hi += (sync[1] === 1'b1);
			@(negedge clk);
		end
		check("sync width", 12'(hi), 12'h008);
		check("sync period", {11'h0, sync[1]}, 12'h001);
		check("lane1 count", cnt[23:12], 12'h000);
		wr(8'h11, 8'hc3);
		wr(8'h12, 8'ha5);
		wr(8'h10, 8'h03);
		pulse(5, 4'h4);
		repeat (60) @(negedge clk);
		check("lane2 clean", cnt[35:24], 12'h000);
		flip = 1'b1;
		@(negedge clk);
		flip = 1'b0;
		repeat (40) @(negedge clk);
		check("lane2 error", {11'h0, cnt[35:24] != 12'h000}, 12'h001);
		check("lane2 mismatch", {11'h0, mm_seen}, 12'h001);
		// lane 1 counts its own disparity events; lane 0 reports the same selection
		wr(8'h16, 8'h20);
		wr(8'h15, 8'h03);
		ev[0] = 4'h2;
		repeat (4100) @(negedge clk);
		ev[0] = 4'h0;
		@(negedge clk);
		check("lane1 saturated", cnt[23:12], 12'hfff);
		check("lane0 saturated", cnt[11:0], 12'hfff);
		rd(8'h17, 8'h72);
		wrap_up();
	end
endmodule
